// >>> rtl/lock_word_receiver.sv
`timescale 1ns/1ps
`default_nettype none
`include "video_timing_params.svh"
module lock_word_receiver
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Serial side
	input wire logic enable_in,
	input wire logic bit_in,
	// Word side
	output logic valid_out,
	output logic [`LOCK_VALUE_BITS-1:0] value_out
);
	logic busy_q;
	logic [7:0] cnt_q;
	logic [7:0] idx;
	logic sample;
	logic last;

	// ----------------------------------------
	// Bit sampling
	// ----------------------------------------
	assign idx = (cnt_q - 8'd3) >> 1;
	assign sample = busy_q & cnt_q[0] & (cnt_q >= 8'd3);
	assign last = sample & (idx == 8'(`LOCK_WORD_BITS - 1));

	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			busy_q <= 1'b0;
			cnt_q <= 8'h00;
			valid_out <= 1'b0;
			value_out <= '0;
		end
		else
		begin
			valid_out <= last;
			if (!busy_q)
			begin
				busy_q <= enable_in & bit_in;
				cnt_q <= 8'h01;
			end
			else
			begin
				cnt_q <= cnt_q + 8'd1;
				busy_q <= ~last;
			end
			if (sample && idx < 8'(`LOCK_VALUE_BITS))
				value_out[idx[4:0]] <= bit_in;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/video_encoder_end.sv
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "video_timing_params.svh"
module video_encoder_end #(
	parameter int PIX_W = 10,
	parameter int SD_LINE_CYCLES = 1716,
	parameter int SD_FIELD_LINES = 263,
	parameter int SD_FIELDS = 8,
	parameter int EDHD_LINE_CYCLES = 2000,
	parameter int EDHD_FRAME_LINES = 1000,
	parameter logic [21:0] FREQ_DEFAULT = 22'h07c1f
)
(
	// Clock and reset
	input wire logic REF_CLK_IN,
	input wire logic RST_B_IN,
	// Link
	video_link_if.dev LINK,
	// AXI4-Lite write
	input wire logic [9:0] S_AWADDR_IN,
	input wire logic S_AWVALID_IN,
	output logic S_AWREADY_OUT,
	input wire logic [31:0] S_WDATA_IN,
	input wire logic [3:0] S_WSTRB_IN,
	input wire logic S_WVALID_IN,
	output logic S_WREADY_OUT,
	output logic [1:0] S_BRESP_OUT,
	output logic S_BVALID_OUT,
	input wire logic S_BREADY_IN,
	// AXI4-Lite read
	input wire logic [9:0] S_ARADDR_IN,
	input wire logic S_ARVALID_IN,
	output logic S_ARREADY_OUT,
	output logic [31:0] S_RDATA_OUT,
	output logic [1:0] S_RRESP_OUT,
	output logic S_RVALID_OUT,
	input wire logic S_RREADY_IN,
	// Video control and status
	output logic PLL1_EN_OUT,
	output logic PLL2_EN_OUT,
	output logic [4:0] SD_OS_OUT,
	output logic [3:0] EDHD_OS_OUT,
	output logic CP_ALLOW_OUT,
	output video_timing_pkg::sync_level_type SYNC_LEVEL_OUT,
	output logic [3:0] SD_FIELD_OUT,
	output logic [21:0] CARRIER_PHASE_OUT,
	output logic [10:0] EDHD_LINE_OUT,
	output logic [PIX_W-1:0] PIXEL_OUT
);
	import video_timing_pkg::*;

	function automatic logic [3:0] next_field(input logic [3:0] f);
		next_field = (f == 4'(SD_FIELDS)) ? 4'h1 : f + 4'h1;
	endfunction

	logic [7:0] pll_q, inmode_q, edmode_q, trst_q, mode2_q, mode4_q, slave_q;
	logic awready_q, wready_q, aw_got_q, w_got_q, arready_q;
	logic [7:0] awidx_q, wdata_q;
	logic wstrb_q;
	logic [3:0] s1_q, s2_q, s3_q;
	logic [PIX_W-1:0] pix1_q;
	logic [10:0] sd_h_q;
	logic [9:0] sd_line_q;
	logic tr_held_q, scr_pend_q, freq_pend_q;
	logic [21:0] freq_q, freq_new_q;
	logic [11:0] eh_q;
	logic rx_valid;
	logic [21:0] rx_value;

	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	wire [2:0] in_mode = inmode_q[`INMODE_LSB +: 3];
	wire pll_off = pll_q[`PLL_OFF_BIT];
	wire hd_sel = slave_q[`HD_SEL_BIT] & (in_mode != `INMODE_ED54);
	wire is_sd = (in_mode == `INMODE_SD);
	wire is_sim = (in_mode == `INMODE_SIM_A) | (in_mode == `INMODE_SIM_B);
	wire is_ed = (in_mode == `INMODE_ED_A) | (in_mode == `INMODE_ED_B) | (in_mode == `INMODE_ED54);
	wire nonstd = (edmode_q[`EDHD_MODE_LSB +: 5] == `EDHD_NONSTD);
	wire [1:0] lock_mode = mode4_q[`LOCK_MODE_LSB +: 2];
	wire tr_mode = (lock_mode == `LOCK_TR);
	wire ls_s = s2_q[0], fs_s = s2_q[1], vs_s = s2_q[2], pin_s = s2_q[3];
	wire ls_fall = ~ls_s & s3_q[0];
	wire ls_rise = ls_s & ~s3_q[0];
	wire fs_rise = fs_s & ~s3_q[1];
	wire vs_fall = ~vs_s & s3_q[2];
	wire pin_rise = pin_s & ~s3_q[3];
	wire trick = mode2_q[`TRICK_BIT] & (slave_q[2:0] != 3'h0);
	wire line_end = (sd_h_q == 11'(SD_LINE_CYCLES - 1));
	wire field_end = line_end & (sd_line_q == 10'(SD_FIELD_LINES - 1));
	wire tr_release = tr_held_q & ~(tr_mode & pin_s);
	wire [3:0] os_edhd = hd_sel ? `OS_HD : `OS_ED;

	wire [4:0] sd_os_d = (is_sd | is_sim) ? (pll_off ? `OS_SD_LOW : `OS_SD_HIGH) : 5'h00;
	wire [3:0] edhd_os_d = nonstd ? `OS_1X : is_sim ? os_edhd : is_ed ? (pll_off ? `OS_1X : os_edhd) : 4'h0;

	wire [7:0] wr_idx = awidx_q;
	wire [7:0] rd_idx = S_ARADDR_IN[9:2];
	wire wr_go = aw_got_q & w_got_q & ~S_BVALID_OUT;
	wire wr_hit = (wr_idx == `REG_IDX_PLL) | (wr_idx == `REG_IDX_INMODE) | (wr_idx == `REG_IDX_EDHD_MODE)
		| (wr_idx == `REG_IDX_EDHD_TRST) | (wr_idx == `REG_IDX_SD_MODE2) | (wr_idx == `REG_IDX_SD_MODE4)
		| (wr_idx == `REG_IDX_FIELD_CNT) | (wr_idx == `REG_IDX_SLAVE_CFG);
	wire rd_hit = (rd_idx == `REG_IDX_PLL) | (rd_idx == `REG_IDX_INMODE) | (rd_idx == `REG_IDX_EDHD_MODE)
		| (rd_idx == `REG_IDX_EDHD_TRST) | (rd_idx == `REG_IDX_SD_MODE2) | (rd_idx == `REG_IDX_SD_MODE4)
		| (rd_idx == `REG_IDX_FIELD_CNT) | (rd_idx == `REG_IDX_SLAVE_CFG);
	wire [7:0] rd_data = (rd_idx == `REG_IDX_PLL) ? pll_q : (rd_idx == `REG_IDX_INMODE) ? inmode_q
		: (rd_idx == `REG_IDX_EDHD_MODE) ? edmode_q : (rd_idx == `REG_IDX_EDHD_TRST) ? trst_q
		: (rd_idx == `REG_IDX_SD_MODE2) ? mode2_q : (rd_idx == `REG_IDX_SD_MODE4) ? mode4_q
		: (rd_idx == `REG_IDX_FIELD_CNT) ? {4'h0, SD_FIELD_OUT} : (rd_idx == `REG_IDX_SLAVE_CFG) ? slave_q : 8'h00;

	lock_word_receiver u_rx (
		.clk_in(REF_CLK_IN),
		.rst_b_in(RST_B_IN),
		.enable_in(lock_mode == `LOCK_SFL),
		.bit_in(pin_s),
		.valid_out(rx_valid),
		.value_out(rx_value)
	);

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	always_ff @(posedge REF_CLK_IN)
	begin
		if (!RST_B_IN)
		begin
			awready_q <= 1'b0; wready_q <= 1'b0; aw_got_q <= 1'b0; w_got_q <= 1'b0;
			awidx_q <= 8'h00; wdata_q <= 8'h00; wstrb_q <= 1'b0;
			S_BVALID_OUT <= 1'b0; S_BRESP_OUT <= `RESP_OKAY;
			arready_q <= 1'b0; S_RVALID_OUT <= 1'b0; S_RDATA_OUT <= 32'h0; S_RRESP_OUT <= `RESP_OKAY;
			pll_q <= `PLL_RESET;
			inmode_q <= `REG_RESET; edmode_q <= `REG_RESET; trst_q <= `REG_RESET;
			mode2_q <= `REG_RESET; mode4_q <= `REG_RESET; slave_q <= `REG_RESET;
		end
		else
		begin
			awready_q <= S_AWVALID_IN & ~awready_q & ~aw_got_q & ~S_BVALID_OUT;
			wready_q <= S_WVALID_IN & ~wready_q & ~w_got_q & ~S_BVALID_OUT;
			if (S_AWVALID_IN & awready_q)
			begin
				aw_got_q <= 1'b1;
				awidx_q <= S_AWADDR_IN[9:2];
			end
			if (S_WVALID_IN & wready_q)
			begin
				w_got_q <= 1'b1;
				wdata_q <= S_WDATA_IN[7:0];
				wstrb_q <= S_WSTRB_IN[0];
			end
			if (wr_go)
			begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				S_BVALID_OUT <= 1'b1;
				S_BRESP_OUT <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
				if (wstrb_q)
				begin
					case (wr_idx)
						`REG_IDX_PLL: pll_q <= wdata_q;
						`REG_IDX_INMODE: inmode_q <= wdata_q;
						`REG_IDX_EDHD_MODE: edmode_q <= wdata_q;
						`REG_IDX_EDHD_TRST: trst_q <= wdata_q;
						`REG_IDX_SD_MODE2: mode2_q <= wdata_q;
						`REG_IDX_SD_MODE4: mode4_q <= wdata_q;
						`REG_IDX_SLAVE_CFG: slave_q <= wdata_q;
						default: pll_q <= pll_q;
					endcase
				end
			end
			else if (S_BVALID_OUT & S_BREADY_IN)
				S_BVALID_OUT <= 1'b0;
			arready_q <= S_ARVALID_IN & ~arready_q & ~S_RVALID_OUT;
			if (S_ARVALID_IN & arready_q)
			begin
				S_RVALID_OUT <= 1'b1;
				S_RDATA_OUT <= {24'h0, rd_data};
				S_RRESP_OUT <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
			end
			else if (S_RVALID_OUT & S_RREADY_IN)
				S_RVALID_OUT <= 1'b0;
		end
	end
	assign S_AWREADY_OUT = awready_q;
	assign S_WREADY_OUT = wready_q;
	assign S_ARREADY_OUT = arready_q;

	// ----------------------------------------
	// Oversampling control and link capture
	// ----------------------------------------
	always_ff @(posedge REF_CLK_IN)
	begin
		if (!RST_B_IN)
		begin
			PLL1_EN_OUT <= 1'b0; PLL2_EN_OUT <= 1'b0; SD_OS_OUT <= 5'h00; EDHD_OS_OUT <= 4'h0;
			CP_ALLOW_OUT <= 1'b0; s1_q <= 4'h5; s2_q <= 4'h5; s3_q <= 4'h5;
			pix1_q <= '0; PIXEL_OUT <= '0;
		end
		else
		begin
			PLL1_EN_OUT <= ~pll_off;
			PLL2_EN_OUT <= is_sim;
			SD_OS_OUT <= sd_os_d;
			EDHD_OS_OUT <= edhd_os_d;
			CP_ALLOW_OUT <= ~nonstd;
			s1_q <= {LINK.shared_lock_pin, LINK.sd_vsync_n, LINK.frame_sync, LINK.line_sync};
			s2_q <= s1_q;
			s3_q <= s2_q;
			pix1_q <= LINK.pixel;
			PIXEL_OUT <= pix1_q;
		end
	end

	// ----------------------------------------
	// SD timing and subcarrier
	// ----------------------------------------
	always_ff @(posedge REF_CLK_IN)
	begin
		if (!RST_B_IN)
		begin
			sd_h_q <= 11'h0; sd_line_q <= 10'h0; SD_FIELD_OUT <= 4'h1; tr_held_q <= 1'b0;
			scr_pend_q <= 1'b0; freq_pend_q <= 1'b0; freq_q <= FREQ_DEFAULT; freq_new_q <= FREQ_DEFAULT;
			CARRIER_PHASE_OUT <= 22'h0;
		end
		else
		begin
			if (tr_mode & pin_s & (pin_rise | tr_held_q))
			begin
				tr_held_q <= 1'b1;
				sd_h_q <= 11'h0;
				sd_line_q <= 10'h0;
			end
			else if (tr_release)
			begin
				tr_held_q <= 1'b0;
				SD_FIELD_OUT <= 4'h1;
			end
			else if (trick & vs_fall)
			begin
				sd_h_q <= 11'h0;
				sd_line_q <= 10'h0;
				SD_FIELD_OUT <= next_field(SD_FIELD_OUT);
			end
			else
			begin
				sd_h_q <= line_end ? 11'h0 : sd_h_q + 11'h1;
				if (line_end)
					sd_line_q <= field_end ? 10'h0 : sd_line_q + 10'h1;
				if (field_end)
					SD_FIELD_OUT <= next_field(SD_FIELD_OUT);
			end
			scr_pend_q <= ((lock_mode == `LOCK_SCR) & pin_rise) | (scr_pend_q & ~field_end);
			if (tr_release | (field_end & scr_pend_q))
				CARRIER_PHASE_OUT <= 22'h0;
			else if (!tr_held_q)
				CARRIER_PHASE_OUT <= CARRIER_PHASE_OUT + freq_q;
			if (rx_valid)
				freq_new_q <= rx_value;
			freq_pend_q <= rx_valid | (freq_pend_q & ~line_end);
			if (line_end & freq_pend_q)
				freq_q <= freq_new_q;
		end
	end

	// ----------------------------------------
	// ED/HD timing and output level
	// ----------------------------------------
	always_ff @(posedge REF_CLK_IN)
	begin
		if (!RST_B_IN)
		begin
			eh_q <= 12'h0; EDHD_LINE_OUT <= 11'h0; SYNC_LEVEL_OUT <= LVL_BLANK;
		end
		else if (trst_q[`EDHD_TRST_BIT])
		begin
			eh_q <= 12'h0; EDHD_LINE_OUT <= 11'h0; SYNC_LEVEL_OUT <= LVL_BLANK;
		end
		else if (nonstd)
		begin
			eh_q <= ls_fall ? 12'h0 : eh_q + 12'h1;
			if (fs_rise & ~ls_s)
				EDHD_LINE_OUT <= 11'h0;
			else if (ls_fall)
				EDHD_LINE_OUT <= EDHD_LINE_OUT + 11'h1;
			case (SYNC_LEVEL_OUT)
				LVL_BLANK: if (ls_fall) SYNC_LEVEL_OUT <= LVL_SYNC;
				LVL_SYNC: if (ls_rise) SYNC_LEVEL_OUT <= LVL_BLANK; else if (fs_rise & ~ls_s) SYNC_LEVEL_OUT <= LVL_TRI;
				LVL_TRI: if (ls_rise) SYNC_LEVEL_OUT <= LVL_BLANK;
				default: SYNC_LEVEL_OUT <= LVL_BLANK;
			endcase
		end
		else
		begin
			SYNC_LEVEL_OUT <= LVL_BLANK;
			eh_q <= (eh_q == 12'(EDHD_LINE_CYCLES - 1)) ? 12'h0 : eh_q + 12'h1;
			if (eh_q == 12'(EDHD_LINE_CYCLES - 1))
				EDHD_LINE_OUT <= (EDHD_LINE_OUT == 11'(EDHD_FRAME_LINES - 1)) ? 11'h0 : EDHD_LINE_OUT + 11'h1;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/video_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface video_link_if #(parameter int PIX_W = 10);
	logic line_sync;
	logic frame_sync;
	logic sd_vsync_n;
	logic shared_lock_pin;
	logic [PIX_W-1:0] pixel;
	modport dev (input line_sync, input frame_sync, input sd_vsync_n, input shared_lock_pin, input pixel);
	modport src (output line_sync, output frame_sync, output sd_vsync_n, output shared_lock_pin, output pixel);
endinterface
`default_nettype wire

// >>> rtl/video_source_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "video_timing_params.svh"
module video_source_end #(parameter int PIX_W = 10, parameter int PULSE_CYCLES = 2)
(
	// Clock and reset
	input wire logic REF_CLK_IN,
	input wire logic RST_B_IN,
	// Link
	video_link_if.src LINK,
	// Sync requests
	input wire video_timing_pkg::sync_level_type LEVEL_REQ_IN,
	input wire logic TRI_EN_IN,
	input wire logic SD_VSYNC_N_IN,
	// Pixels
	input wire logic ACTIVE_IN,
	input wire logic [PIX_W-1:0] PIXEL_IN,
	// Lock pin requests
	input wire logic PULSE_REQ_IN,
	input wire logic LOCK_SEND_IN,
	input wire logic [`LOCK_VALUE_BITS-1:0] LOCK_WORD_IN,
	output logic LOCK_BUSY_OUT
);
	import video_timing_pkg::*;

	logic ls_q;
	logic fs_q;
	logic vs_q;
	logic pin_q;
	logic [PIX_W-1:0] pix_q;
	lock_tx_type tx_q;
	logic [7:0] cnt_q;
	logic [`LOCK_WORD_BITS+1:0] sh_q;
	logic ls_d;
	logic fs_d;
	logic tx_step;

	// ----------------------------------------
	// Sync toggling
	// ----------------------------------------
	// Sync edge sequence
	assign ls_d = (LEVEL_REQ_IN == LVL_BLANK);
	assign fs_d = TRI_EN_IN & (LEVEL_REQ_IN == LVL_TRI ? ~ls_q : (LEVEL_REQ_IN == LVL_BLANK) & fs_q);
	assign tx_step = (cnt_q == 8'(`LOCK_BIT_CYCLES - 1));

	assign LINK.line_sync = ls_q;
	assign LINK.frame_sync = fs_q;
	assign LINK.sd_vsync_n = vs_q;
	assign LINK.shared_lock_pin = pin_q;
	assign LINK.pixel = pix_q;

	always_ff @(posedge REF_CLK_IN)
	begin
		if (!RST_B_IN)
		begin
			ls_q <= 1'b1;
			fs_q <= 1'b0;
			vs_q <= 1'b1;
			pix_q <= `BLANK_CODE;
		end
		else
		begin
			ls_q <= ls_d;
			fs_q <= fs_d;
			vs_q <= SD_VSYNC_N_IN;
			pix_q <= (ACTIVE_IN && LEVEL_REQ_IN == LVL_BLANK) ? PIXEL_IN : `BLANK_CODE;
		end
	end

	// ----------------------------------------
	// Lock pin driver
	// ----------------------------------------
	always_ff @(posedge REF_CLK_IN)
	begin
		if (!RST_B_IN)
		begin
			tx_q <= TX_IDLE;
			cnt_q <= 8'h00;
			sh_q <= '0;
			pin_q <= 1'b0;
			LOCK_BUSY_OUT <= 1'b0;
		end
		else
		begin
			case (tx_q)
				TX_IDLE:
				begin
					cnt_q <= 8'h00;
					if (PULSE_REQ_IN)
					begin
						tx_q <= TX_PULSE;
						pin_q <= 1'b1;
						LOCK_BUSY_OUT <= 1'b1;
					end
					else if (LOCK_SEND_IN)
					begin
						tx_q <= TX_WORD;
						sh_q <= {1'b1, (`LOCK_WORD_BITS - `LOCK_VALUE_BITS)'(0), LOCK_WORD_IN, 1'b1};
						pin_q <= 1'b1;
						LOCK_BUSY_OUT <= 1'b1;
					end
					else
						pin_q <= 1'b0;
				end
				TX_PULSE:
				begin
					cnt_q <= cnt_q + 8'd1;
					if (cnt_q == 8'(PULSE_CYCLES - 1))
					begin
						tx_q <= TX_IDLE;
						pin_q <= 1'b0;
						LOCK_BUSY_OUT <= 1'b0;
					end
				end
				TX_WORD:
				begin
					cnt_q <= tx_step ? 8'h00 : cnt_q + 8'd1;
					if (tx_step)
					begin
						sh_q <= sh_q >> 1;
						pin_q <= sh_q[1];
						if (sh_q[`LOCK_WORD_BITS+1:1] == (`LOCK_WORD_BITS+1)'(1))
						begin
							tx_q <= TX_IDLE;
							pin_q <= 1'b0;
							LOCK_BUSY_OUT <= 1'b0;
						end
					end
				end
				default:
					tx_q <= TX_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> rtl/video_timing_params.svh
`ifndef VIDEO_TIMING_PARAMS_SVH
`define VIDEO_TIMING_PARAMS_SVH

// ----------------------------------------
// Register indices, byte address is index times four
// ----------------------------------------
`define REG_IDX_PLL 8'h00
`define REG_IDX_INMODE 8'h01
`define REG_IDX_EDHD_MODE 8'h30
`define REG_IDX_EDHD_TRST 8'h34
`define REG_IDX_SD_MODE2 8'h82
`define REG_IDX_SD_MODE4 8'h84
`define REG_IDX_FIELD_CNT 8'hbb
`define REG_IDX_SLAVE_CFG 8'hc0

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PLL_OFF_BIT 1
`define INMODE_LSB 4
`define EDHD_MODE_LSB 3
`define EDHD_TRST_BIT 0
`define TRICK_BIT 5
`define LOCK_MODE_LSB 1
`define HD_SEL_BIT 3
`define PLL_RESET 8'h02
`define REG_RESET 8'h00

// ----------------------------------------
// Mode codes
// ----------------------------------------
`define INMODE_SD 3'h0
`define INMODE_ED_A 3'h1
`define INMODE_ED_B 3'h2
`define INMODE_SIM_A 3'h3
`define INMODE_SIM_B 3'h4
`define INMODE_ED54 3'h7
`define EDHD_NONSTD 5'h01
`define LOCK_TR 2'h2
`define LOCK_SCR 2'h1
`define LOCK_SFL 2'h3

// ----------------------------------------
// Rates and timing counts
// ----------------------------------------
`define OS_SD_LOW 5'h02
`define OS_SD_HIGH 5'h10
`define OS_1X 4'h1
`define OS_HD 4'h4
`define OS_ED 4'h8
`define LOCK_WORD_BITS 67
`define LOCK_VALUE_BITS 22
`define LOCK_BIT_CYCLES 2
`define PULSE_MIN_CYCLES 1
`define BLANK_CODE 10'h040
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// >>> rtl/video_timing_pkg.sv
package video_timing_pkg;
	typedef enum logic [1:0] {LVL_BLANK, LVL_SYNC, LVL_TRI} sync_level_type;
	typedef enum logic [1:0] {TX_IDLE, TX_PULSE, TX_WORD} lock_tx_type;
endpackage

// >>> testbench/video_encoder_timing_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "video_timing_params.svh"
`define CK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module video_encoder_timing_control_bench;
	import video_timing_pkg::*;
	typedef struct packed {logic [2:0] m; logic p; logic h; logic [4:0] s; logic [3:0] e; logic q;} row_type;
	row_type rows [12] = '{15'h0840, 15'h0200, 15'h1802, 15'h2010, 15'h1c02, 15'h2408,
		15'h3851, 15'h4211, 15'h3c49, 15'h4609, 15'h7c02, 15'h7410};
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [9:0] awa = 10'h000;
	logic [9:0] ara = 10'h000;
	logic [31:0] wd = 32'h00000000;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic br = 1'b0;
	logic arv = 1'b0;
	logic rr = 1'b0;
	sync_level_type lvl_req = LVL_BLANK;
	logic tri_en = 1'b1;
	logic vs_n = 1'b1;
	logic pulse_req = 1'b0;
	logic send = 1'b0;
	logic active = 1'b1;
	logic [3:0] ws = 4'hf;
	logic [9:0] pix_i = 10'h155;
	logic [21:0] lw = 22'h2a5a5;
	logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, busy, pll1, pll2, cp_ok;
	logic [1:0] b_resp, r_resp;
	logic [31:0] r_data;
	sync_level_type lvl;
	logic [4:0] sd_os;
	logic [3:0] ed_os, field, f0;
	logic [21:0] phase, p0;
	logic [10:0] eline, e0;
	logic [9:0] pix_o;
	logic [8:0] n;
	// ----------------------------------------
	// Both ends joined by the link.
	// ----------------------------------------
	video_link_if link ();
	video_source_end u_video_source_end (.REF_CLK_IN(clk), .RST_B_IN(rst_b),
		.LINK(link.src), .LEVEL_REQ_IN(lvl_req), .TRI_EN_IN(tri_en), .SD_VSYNC_N_IN(vs_n), .ACTIVE_IN(active),
		.PIXEL_IN(pix_i), .PULSE_REQ_IN(pulse_req), .LOCK_SEND_IN(send), .LOCK_WORD_IN(lw),
		.LOCK_BUSY_OUT(busy));
	video_encoder_end #(.SD_LINE_CYCLES(20), .SD_FIELD_LINES(4), .EDHD_LINE_CYCLES(16),
		.EDHD_FRAME_LINES(4)) u_video_encoder_end (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .LINK(link.dev),
		.S_AWADDR_IN(awa), .S_AWVALID_IN(awv), .S_AWREADY_OUT(aw_rdy), .S_WDATA_IN(wd), .S_WSTRB_IN(ws),
		.S_WVALID_IN(wv), .S_WREADY_OUT(w_rdy), .S_BRESP_OUT(b_resp), .S_BVALID_OUT(b_vld), .S_BREADY_IN(br),
		.S_ARADDR_IN(ara), .S_ARVALID_IN(arv), .S_ARREADY_OUT(ar_rdy), .S_RDATA_OUT(r_data),
		.S_RRESP_OUT(r_resp), .S_RVALID_OUT(r_vld), .S_RREADY_IN(rr), .PLL1_EN_OUT(pll1), .PLL2_EN_OUT(pll2),
		.SD_OS_OUT(sd_os), .EDHD_OS_OUT(ed_os), .CP_ALLOW_OUT(cp_ok), .SYNC_LEVEL_OUT(lvl),
		.SD_FIELD_OUT(field), .CARRIER_PHASE_OUT(phase), .EDHD_LINE_OUT(eline), .PIXEL_OUT(pix_o));
	video_encoder_timing_control_monitor u_video_encoder_timing_control_monitor (.REF_CLK_IN(clk),
		.RST_B_IN(rst_b), .line_sync(link.line_sync), .frame_sync(link.frame_sync),
		.sd_vsync_n(link.sd_vsync_n), .shared_lock_pin(link.shared_lock_pin), .pixel(link.pixel));
	// ----------------------------------------
	// Clock, timeout and tasks.
	// ----------------------------------------
	initial
	begin
		forever #2 clk = ~clk;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] rs;
		tb = 1'b0;
		@(posedge clk);
		awa <= a;
		wd <= {24'h000000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		while (!tb)
		begin
			@(negedge clk);
			ta = aw_rdy & awv;
			tw = w_rdy & wv;
			tb = b_vld;
			rs = b_resp;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end
		br <= 1'b0;
		`CK(rs, er)
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
		logic tr, tv;
		logic [31:0] q;
		logic [1:0] rs;
		tv = 1'b0;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		while (!tv)
		begin
			@(negedge clk);
			tr = ar_rdy & arv;
			tv = r_vld;
			q = r_data;
			rs = r_resp;
			@(posedge clk);
			if (tr) arv <= 1'b0;
		end
		rr <= 1'b0;
		`CK(q, {24'h000000, d})
		`CK(rs, er)
	endtask
	function automatic logic [3:0] nxt(input logic [3:0] f);
		return (f == 4'h8) ? 4'h1 : f + 4'h1;
	endfunction
	task automatic wfield(input logic [3:0] f);
		for (int k = 0; k < 800 && field !== f; k++)
			@(negedge clk);
	endtask
	task automatic pulse();
		@(posedge clk);
		pulse_req <= 1'b1;
		@(posedge clk);
		pulse_req <= 1'b0;
		@(negedge clk);
	endtask
	task automatic step(input sync_level_type q, input sync_level_type e);
		@(posedge clk);
		lvl_req <= q;
		repeat (8) @(negedge clk);
		`CK(lvl, e)
	endtask
	task automatic trick(input logic [2:0] sm, input logic adv);
		logic [3:0] f;
		wr(10'h300, {5'h00, sm}, `RESP_OKAY);
		@(negedge clk);
		wfield(nxt(field));
		f = field;
		@(posedge clk);
		vs_n <= 1'b0;
		@(posedge clk);
		vs_n <= 1'b1;
		repeat (8) @(negedge clk);
		`CK(field, adv ? nxt(f) : f)
	endtask
	// ----------------------------------------
	// Test sequence.
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		`CK(pll1, 1'b0)
		`CK(field, 4'h1)
		repeat (2) @(negedge clk);
		`CK(sd_os, `OS_SD_LOW)
		rd(10'h000, `PLL_RESET, `RESP_OKAY);
		rd(10'h3fc, 8'h00, `RESP_DECERR);
		wr(10'h3fc, 8'h5a, `RESP_DECERR);
		ws <= 4'h0;
		wr(10'h000, 8'h00, `RESP_OKAY);
		ws <= 4'hf;
		rd(10'h000, `PLL_RESET, `RESP_OKAY);
		`CK(pll1, 1'b0)
		$display("done reset");
		foreach (rows[i])
		begin
			wr(10'h004, {1'b0, rows[i].m, 4'h0}, `RESP_OKAY);
			wr(10'h000, {6'h00, rows[i].p, 1'b0}, `RESP_OKAY);
			wr(10'h300, {4'h0, rows[i].h, 3'h0}, `RESP_OKAY);
			repeat (3) @(negedge clk);
			`CK(sd_os, rows[i].s)
			`CK(ed_os, rows[i].e)
			`CK(pll2, rows[i].q)
			`CK(pll1, ~rows[i].p)
			`CK(cp_ok, 1'b1)
		end
		$display("done rates");
		wr(10'h004, 8'h30, `RESP_OKAY);
		wr(10'h0d0, 8'h01, `RESP_OKAY);
		@(negedge clk);
		f0 = field;
		repeat (100) @(negedge clk);
		`CK(eline, 11'h000)
		`CK(field != f0, 1'b1)
		wr(10'h0d0, 8'h00, `RESP_OKAY);
		repeat (40) @(negedge clk);
		`CK(eline != 11'h000, 1'b1)
		wr(10'h210, 8'h04, `RESP_OKAY);
		wfield(4'h3);
		pulse();
		e0 = eline;
		repeat (40) @(negedge clk);
		`CK(field, 4'h1)
		`CK(eline != e0, 1'b1)
		rd(10'h2ec, 8'h01, `RESP_OKAY);
		wr(10'h210, 8'h02, `RESP_OKAY);
		wfield(4'h3);
		pulse();
		wfield(4'h4);
		`CK(field, 4'h4)
		`CK(phase, 22'h000000)
		$display("done counters");
		wr(10'h210, 8'h06, `RESP_OKAY);
		@(posedge clk);
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		n = 9'h000;
		repeat (300)
		begin
			@(negedge clk);
			n = n + {8'h00, busy};
		end
		`CK(n, 9'h088)
		p0 = phase;
		@(negedge clk);
		`CK(phase - p0, lw)
		$display("done lock");
		step(LVL_SYNC, LVL_BLANK);
		step(LVL_BLANK, LVL_BLANK);
		wr(10'h0c0, 8'h08, `RESP_OKAY);
		repeat (3) @(negedge clk);
		`CK(ed_os, `OS_1X)
		`CK(cp_ok, 1'b0)
		step(LVL_SYNC, LVL_SYNC);
		`CK(pix_o, `BLANK_CODE)
		step(LVL_TRI, LVL_TRI);
		`CK(eline, 11'h000)
		step(LVL_BLANK, LVL_BLANK);
		`CK(pix_o, pix_i)
		@(posedge clk);
		active <= 1'b0;
		repeat (4) @(negedge clk);
		`CK(pix_o, `BLANK_CODE)
		@(posedge clk);
		active <= 1'b1;
		step(LVL_SYNC, LVL_SYNC);
		`CK(eline, 11'h001)
		@(posedge clk);
		tri_en <= 1'b0;
		step(LVL_TRI, LVL_SYNC);
		step(LVL_BLANK, LVL_BLANK);
		$display("done nonstd");
		wr(10'h208, 8'h20, `RESP_OKAY);
		trick(3'h0, 1'b0);
		trick(3'h1, 1'b1);
		$display("done trick");
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		`CK(field, 4'h1)
		`CK(lvl, LVL_BLANK)
		`CK(phase, 22'h000000)
		`CK(sd_os, 5'h00)
		@(negedge clk);
		`CK(pll1, 1'b0)
		`CK(sd_os, `OS_SD_LOW)
		rd(10'h208, 8'h00, `RESP_OKAY);
		$display("done mid reset");
		end_sim();
	end
endmodule
`default_nettype wire

// >>> testbench/video_encoder_timing_control_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "video_timing_params.svh"
module video_encoder_timing_control_monitor
(
	// Clock and reset
	input wire logic REF_CLK_IN,
	input wire logic RST_B_IN,
	// Link
	input wire logic line_sync,
	input wire logic frame_sync,
	input wire logic sd_vsync_n,
	input wire logic shared_lock_pin,
	input wire logic [9:0] pixel
);
	// ----------------------------------------
	// Length of the current high run on the lock pin.
	// ----------------------------------------
	logic [7:0] high_q;
	logic [7:0] high_d;
	assign high_d = shared_lock_pin ? high_q + 8'h01 : 8'h00;
	always_ff @(posedge REF_CLK_IN)
	begin
		high_q <= RST_B_IN ? high_d : 8'h00;
	end
	// ----------------------------------------
	// Link assertions.
	// ----------------------------------------
	default clocking @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!RST_B_IN);
	property p_tri_from_sync;
		$rose(frame_sync) |-> !line_sync;
	endproperty
	a_tri_from_sync: assert property (p_tri_from_sync)
		else $error("frame sync rose with line sync high");
	property p_sync_frame_low;
		$fell(line_sync) |-> !frame_sync;
	endproperty
	a_sync_frame_low: assert property (p_sync_frame_low)
		else $error("frame sync high when line sync fell");
	property p_blank_pixel;
		!line_sync && !$past(line_sync) |-> pixel == `BLANK_CODE;
	endproperty
	a_blank_pixel: assert property (p_blank_pixel)
		else $error("pixel not blank during sync");
	property p_pulse_min;
		$rose(shared_lock_pin) |=> shared_lock_pin;
	endproperty
	a_pulse_min: assert property (p_pulse_min)
		else $error("lock pin pulse too short");
	property p_bit_even;
		$fell(shared_lock_pin) |-> high_q[0] == 1'b0 && high_q != 8'h00;
	endproperty
	a_bit_even: assert property (p_bit_even)
		else $error("lock pin high run not whole bits");
	property p_run_max;
		shared_lock_pin |-> high_q < 8'h88;
	endproperty
	a_run_max: assert property (p_run_max)
		else $error("lock pin high longer than a word");
	property p_idle_reset;
		disable iff (1'b0)
		!RST_B_IN |=> line_sync && !frame_sync && sd_vsync_n && !shared_lock_pin && pixel == `BLANK_CODE;
	endproperty
	a_idle_reset: assert property (p_idle_reset)
		else $error("link not idle after reset");
	c_tri: cover property ($rose(frame_sync));
	c_sync: cover property ($fell(line_sync));
	c_word: cover property ($fell(shared_lock_pin) && high_q > 8'h02);
endmodule
`default_nettype wire
